// [tb_wake_source_config_regs.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: an integer model of the three registers predicts every
// read and every decoded output of the design.
module tb_wake_source_config_regs;
  logic       core_clk = 1'b0; // 100 MHz clock.
  logic       rst = 1'b1;      // Synchronous reset.
  logic       soft_reset = 1'b0, restart_entry = 1'b0, fail_safe_entry = 1'b0;
  logic       wd_update_valid = 1'b0, wd_update_value = 1'b0;
  logic       wake_event_any = 1'b0, status_event_any = 1'b0;
  logic [2:0] wake_pin_level = 3'h0;
  logic [6:0] reg_addr;
  logic       reg_wr_en, reg_rd_en, reg_rd_valid, int_trigger;
  logic [7:0] reg_wr_data, reg_rd_data;
  logic       t2_en, t1_en, wd_dis, meas, pa_en, pb_en, pc_en;
  logic [1:0] pa_pull, pb_pull, pc_pull;
  logic [2:0] lvl_stat;
  int         errors = 0, n_compared = 0;
  int         mi, me, mp;               // Model of the three registers.
  logic [31:0] seed = 32'hF5FC7B5A;     // Fixed seed of the random source.

  always #5 core_clk = ~core_clk;

  wsc_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid));

  wsc_wake_regs DUT (.core_clk(core_clk), .rst(rst), .soft_reset(soft_reset), .restart_entry(restart_entry),
    .fail_safe_entry(fail_safe_entry), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .wd_update_valid(wd_update_valid), .wd_update_value(wd_update_value),
    .wake_event_any(wake_event_any), .status_event_any(status_event_any), .wake_pin_level(wake_pin_level),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .second_timer_wake_enable(t2_en),
    .first_timer_wake_enable(t1_en), .watchdog_stop_disable(wd_dis), .wake_or_measure_select(meas),
    .wake_pin_a_enable(pa_en), .wake_pin_b_enable(pb_en), .wake_pin_c_enable(pc_en),
    .wake_pin_a_pull_select(pa_pull), .wake_pin_b_pull_select(pb_pull), .wake_pin_c_pull_select(pc_pull),
    .wake_pin_level_status(lvl_stat), .int_trigger(int_trigger));

  ////////////////////////////////////////////////////////////////////////////////
  // Xorshift source, so a run is always repeatable.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // The one comparison for every kind of result.
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Read one register and compare the answer with the model.
  task automatic rdchk(input logic [6:0] a, input int e);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk("read valid", 8'h01, {7'h00, v});
    chk("read data", e[7:0], d);
  endtask

  // Decoded outputs; pins a and b lose their enables in measure mode.
  task automatic outs();
    chk("int fields", {5'h00, mi[7], mi[6], mi[2]}, {5'h00, t2_en, t1_en, wd_dis});
    chk("measure", {7'h00, me[5]}, {7'h00, meas});
    chk("pin enables", {5'h00, me[2], me[1] & ~me[5], me[0] & ~me[5]}, {5'h00, pc_en, pb_en, pa_en});
    chk("pulls", {2'h0, mp[5:0]}, {2'h0, pc_pull, pb_pull, pa_pull});
  endtask

  task automatic all_regs();
    rdchk(7'h06, mi);
    rdchk(7'h07, me);
    rdchk(7'h08, mp);
    outs();
  endtask

  // One-cycle pulse on an event input, launched at a falling edge.
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask

  task finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Guard against a hang; the tests need well under a thousand cycles.
  initial begin
    #100000;
    errors++;
    finish_test;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [6:0]  a;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    mi = 0; me = 7; mp = 0;
    all_regs();
    $display("Test reset values done");
    // Random writes over addresses 0x05 to 0x09, unmapped ones on both sides included.
    for (int i = 0; i < 30; i++) begin
      r = xs();
      a = 7'h05 + 7'(r[10:8] % 5);
      host.wr(a, r[7:0]);
      if (a == 7'h06) mi = r[7:0] & 8'hC4;
      if (a == 7'h07) me = r[7:0] & 8'hA7;
      if (a == 7'h08) mp = r[7:0] & 8'h3F;
      outs();
      rdchk(a, (a >= 7'h06 && a <= 7'h08) ? (a == 7'h06 ? mi : a == 7'h07 ? me : mp) : 0);
    end
    $display("Test random access done");
    // The device update of the watchdog bit beats a host write in the same cycle.
    wd_update_value = 1'b1;
    fork
      host.wr(7'h06, 8'hC0);
      pulse(wd_update_valid);
    join
    mi = 'hC4;
    rdchk(7'h06, mi);
    wd_update_value = 1'b0;
    pulse(wd_update_valid);
    mi = 'hC0;
    outs();
    $display("Test watchdog bit done");
    // Fail-safe keeps scope and measure, forces all pin enable bits on, beats the host write.
    host.wr(7'h07, 8'hA0);
    fork
      host.wr(7'h07, 8'h00);
      pulse(fail_safe_entry);
    join
    me = 'hA7;
    all_regs();
    host.wr(7'h07, 8'h20);
    me = 'h20;
    pulse(restart_entry);
    all_regs();
    $display("Test fail-safe and restart done");
    // Interrupt scope against every mix of wake and other status events.
    for (int s = 0; s < 2; s++) begin
      host.wr(7'h07, {s[0], 7'h07});
      me = s * 128 + 7;
      for (int e = 0; e < 4; e++) begin
        @(negedge core_clk);
        wake_event_any = e[0];
        status_event_any = e[1];
        @(negedge core_clk);
        chk("int trigger", {7'h00, e[0] | (s[0] & e[1])}, {7'h00, int_trigger});
      end
    end
    wake_event_any = 1'b0;
    status_event_any = 1'b0;
    $display("Test interrupt scope done");
    // Level status of pins a and b is hidden in measure mode.
    for (int m = 0; m < 2; m++) begin
      host.wr(7'h07, {2'h0, m[0], 5'h07});
      me = m * 32 + 7;
      r = xs();
      @(negedge core_clk);
      wake_pin_level = r[2:0] | 3'h3;
      repeat (3) @(negedge core_clk);
      chk("level status", {5'h00, wake_pin_level & (m[0] ? 3'h4 : 3'h7)}, {5'h00, lvl_stat});
      outs();
    end
    $display("Test measure masking done");
    // Soft reset restores every register.
    host.wr(7'h06, 8'hFF);
    host.wr(7'h08, 8'hFF);
    pulse(soft_reset);
    mi = 0; me = 7; mp = 0;
    all_regs();
    $display("Test soft reset done");
    finish_test;
  end
endmodule // tb_wake_source_config_regs

// [wsc_host_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Host side of the register port. Each access is one strobe cycle launched at
// a falling edge; between accesses the address and data lines show the inverse
// of the last value so that stale values are never mistaken for fresh ones.
module wsc_host_model (
  input  wire logic       core_clk,
  output logic      [6:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wr_data,
  output logic            reg_rd_en,
  input  wire logic [7:0] reg_rd_data,
  input  wire logic       reg_rd_valid
);
  // Idle bus state at time zero.
  initial begin
    reg_addr    = 7'h7F;
    reg_wr_en   = 1'b0;
    reg_wr_data = 8'hFF;
    reg_rd_en   = 1'b0;
  end

  // seven-bit addressing.
  // One write strobe; the register updates at the rising edge in between.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr    = a;
    reg_wr_data = d;
    reg_wr_en   = 1'b1;
    @(negedge core_clk);
    reg_wr_en   = 1'b0;
    reg_addr    = ~a;
    reg_wr_data = ~d;
  endtask

  // One read strobe; the answer stands for the cycle after the strobe edge.
  // Bus wake modes are set elsewhere, never through this group.
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge core_clk);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    d         = reg_rd_data;
    v         = reg_rd_valid;
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
  endtask
endmodule // wsc_host_model

// [wsc_pkg.sv]
package wsc_pkg;
  // Register addresses on the 7-bit serial access port.
  localparam logic [6:0] INT_WAKE_ADDR  = 7'h06;
  localparam logic [6:0] EXT_WAKE_ADDR  = 7'h07;
  localparam logic [6:0] PULL_ADDR      = 7'h08;
  // Reset values after power-on or soft reset.
  localparam logic [7:0] INT_WAKE_RST   = 8'h00;
  localparam logic [7:0] EXT_WAKE_RST   = 8'h07;
  localparam logic [7:0] PULL_RST       = 8'h00;
  // Writable bit masks; every other bit is reserved and reads zero.
  localparam logic [7:0] INT_WAKE_WMASK = 8'hC4;
  localparam logic [7:0] EXT_WAKE_WMASK = 8'hA7;
  localparam logic [7:0] PULL_WMASK     = 8'h3F;
  // Fail-safe entry keeps these bits of the external register and forces the rest.
  localparam logic [7:0] FAIL_KEEP_MASK = 8'hA0;
  localparam logic [7:0] FAIL_SET_BITS  = 8'h07;
  // Restart keeps these bits of the external register and clears the rest.
  localparam logic [7:0] RESTART_KEEP   = 8'hA7;
  // Field positions in the internal register.
  localparam int TIMER2_WAKE_BIT = 7;
  localparam int TIMER1_WAKE_BIT = 6;
  localparam int WD_STOP_BIT     = 2;
  // Field positions in the external register.
  localparam int INT_SCOPE_BIT   = 7;
  localparam int MEASURE_BIT     = 5;
  localparam int PIN_C_EN_BIT    = 2;
  localparam int PIN_B_EN_BIT    = 1;
  localparam int PIN_A_EN_BIT    = 0;
  // Pull field positions, low bit of each two-bit field.
  localparam int PULL_C_LSB      = 4;
  localparam int PULL_B_LSB      = 2;
  localparam int PULL_A_LSB      = 0;
  // Pull field encodings.
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;
  // Count of wake pins.
  localparam int PIN_COUNT       = 3;
endpackage : wsc_pkg

// [wsc_wake_regs.sv]
`timescale 1ns/1ps
// Function
// - Bit 7 enables second timer wake.
// - Bit 6 enables first timer wake.
// - Reserved bits always read back zero.
// - Bit 2 disables watchdog in stop.
// - Bit 7 widens interrupt to all status.
// - Measure mode blocks pins a, b waking.
// - Bit 2 enables pin c wake.
// - Bit 1 enables pin b wake.
// - Measure mode also hides pin a/b levels.
// - Fail-safe forces external register to x0x0_0111.
// - External resets 0x07; restart clears reserved only.
// - Internal register resets to zero.
// - Two-bit pull field per wake pin.
// - Pull register resets to zero.
module wsc_wake_regs (
  input  wire logic       core_clk,              // System clock, 100 MHz.
  input  wire logic       rst,                   // Synchronous reset, active high.
  input  wire logic       soft_reset,            // Soft reset pulse from the command decoder.
  input  wire logic       restart_entry,         // Pulse on entering restart mode.
  input  wire logic       fail_safe_entry,       // Pulse on entering fail-safe mode.
  input  wire logic [6:0] reg_addr,              // Register address from the serial frame.
  input  wire logic       reg_wr_en,             // One-cycle write strobe.
  input  wire logic [7:0] reg_wr_data,           // Write data.
  input  wire logic       reg_rd_en,             // One-cycle read strobe.
  input  wire logic       wd_update_valid,       // Device-side update of the watchdog bit.
  input  wire logic       wd_update_value,       // New value for the watchdog bit.
  input  wire logic       wake_event_any,        // Any wake status bit set.
  input  wire logic       status_event_any,      // Any other status bit set.
  input  wire logic [2:0] wake_pin_level,        // Raw pin levels, index 0 is pin a.
  output logic      [7:0] reg_rd_data,           // Read data, valid with reg_rd_valid.
  output logic            reg_rd_valid,          // One-cycle read answer.
  output logic            second_timer_wake_enable,
  output logic            first_timer_wake_enable,
  output logic            watchdog_stop_disable,
  output logic            wake_or_measure_select,
  output logic            wake_pin_a_enable,     // Effective enables after measure override.
  output logic            wake_pin_b_enable,
  output logic            wake_pin_c_enable,
  output logic      [1:0] wake_pin_a_pull_select,
  output logic      [1:0] wake_pin_b_pull_select,
  output logic      [1:0] wake_pin_c_pull_select,
  output logic      [2:0] wake_pin_level_status, // Synchronised levels, pins a and b masked in measure mode.
  output logic            int_trigger            // Interrupt request towards the pin driver.
);

  //////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [7:0] int_wake;       // Internal wake source register.
  logic [7:0] ext_wake;       // External wake source register.
  logic [7:0] pull_ctrl;      // Pull configuration register.
  logic [7:0] next_int_wake;  // Next internal register value.
  logic [7:0] next_ext_wake;  // Next external register value.
  logic [7:0] next_pull_ctrl; // Next pull register value.
  logic       hit_int;        // Write decodes to the internal register.
  logic       hit_ext;        // Write decodes to the external register.
  logic       hit_pull;       // Write decodes to the pull register.

  // Update of the three registers; soft reset beats fail-safe beats restart beats writes.
  always_comb begin
    hit_int        = reg_wr_en && (reg_addr == wsc_pkg::INT_WAKE_ADDR);
    hit_ext        = reg_wr_en && (reg_addr == wsc_pkg::EXT_WAKE_ADDR);
    hit_pull       = reg_wr_en && (reg_addr == wsc_pkg::PULL_ADDR);
    next_int_wake  = int_wake;
    next_ext_wake  = ext_wake;
    next_pull_ctrl = pull_ctrl;
    if (hit_int) begin
      next_int_wake = reg_wr_data & wsc_pkg::INT_WAKE_WMASK;
    end
    if (hit_ext) begin
      next_ext_wake = reg_wr_data & wsc_pkg::EXT_WAKE_WMASK;
    end
    if (hit_pull) begin
      next_pull_ctrl = reg_wr_data & wsc_pkg::PULL_WMASK;
    end
    // device watchdog update
    // The device's own update wins over a host write in the same cycle.
    if (wd_update_valid) begin
      next_int_wake[wsc_pkg::WD_STOP_BIT] = wd_update_value;
    end
    if (restart_entry) begin
      next_ext_wake = ext_wake & wsc_pkg::RESTART_KEEP;
    end
    // fail-safe wake forcing
    // A failure sets every pin enable bit but keeps the measure bit, and this beats any host write.
    if (fail_safe_entry) begin
      next_ext_wake = (ext_wake & wsc_pkg::FAIL_KEEP_MASK) | wsc_pkg::FAIL_SET_BITS;
    end
    // soft reset of all three registers
    if (soft_reset) begin
      next_int_wake  = wsc_pkg::INT_WAKE_RST;
      next_ext_wake  = wsc_pkg::EXT_WAKE_RST;
      next_pull_ctrl = wsc_pkg::PULL_RST;
    end
  end

  // Register stage; power-on reset loads the documented values.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_wake  <= wsc_pkg::INT_WAKE_RST;
      ext_wake  <= wsc_pkg::EXT_WAKE_RST;
      pull_ctrl <= wsc_pkg::PULL_RST;
    end else begin
      int_wake  <= next_int_wake;
      ext_wake  <= next_ext_wake;
      pull_ctrl <= next_pull_ctrl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port.

  logic [7:0] next_rd_data;  // Next read data.
  logic       next_rd_valid; // Next read answer strobe.

  // Read mux; unmapped addresses answer zero rather than stalling the frame.
  always_comb begin
    next_rd_valid = reg_rd_en;
    next_rd_data  = 8'h00;
    if (reg_rd_en) begin
      case (reg_addr)
        wsc_pkg::INT_WAKE_ADDR: next_rd_data = int_wake & wsc_pkg::INT_WAKE_WMASK;
        wsc_pkg::EXT_WAKE_ADDR: next_rd_data = ext_wake & wsc_pkg::EXT_WAKE_WMASK;
        wsc_pkg::PULL_ADDR:     next_rd_data = pull_ctrl & wsc_pkg::PULL_WMASK;
        default:                next_rd_data = 8'h00;
      endcase
    end
  end

  // Read answer registers.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_data  <= next_rd_data;
      reg_rd_valid <= next_rd_valid;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin level synchronisers, one per wake pin.

  logic [2:0] level_meta; // First stage, read only by the second stage.
  logic [2:0] level_sync; // Second stage, safe to use.

  genvar gi;
  generate
    for (gi = 0; gi < wsc_pkg::PIN_COUNT; gi = gi + 1) begin : g_sync
      // Two-flop synchroniser for an asynchronous pin level.
      always_ff @(posedge core_clk) begin
        if (rst) begin
          level_meta[gi] <= 1'b0;
          level_sync[gi] <= 1'b0;
        end else begin
          level_meta[gi] <= wake_pin_level[gi];
          level_sync[gi] <= level_meta[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Decoded control outputs, taken from the next register values except the interrupt
  // scope, so that they move on the same edge as the registers themselves.

  logic       next_meas;   // Measure mode from the next external value.
  logic [2:0] next_en;     // Effective pin enables.
  logic [2:0] next_level;  // Masked level status.
  logic       next_int;    // Interrupt request.

  // Effective enables and masked levels.
  always_comb begin
    next_meas = next_ext_wake[wsc_pkg::MEASURE_BIT];
    next_en[0] = next_ext_wake[wsc_pkg::PIN_A_EN_BIT] && !next_meas;
    next_en[1] = next_ext_wake[wsc_pkg::PIN_B_EN_BIT] && !next_meas;
    next_en[2] = next_ext_wake[wsc_pkg::PIN_C_EN_BIT];
    next_level = {level_sync[2], level_sync[1:0] & {2{!next_meas}}};
    // interrupt scope select
    // The scope bit in use is the stored one, so a write changes scope a cycle later.
    next_int = ext_wake[wsc_pkg::INT_SCOPE_BIT] ? (wake_event_any || status_event_any) : wake_event_any;
  end

  // Output registers.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      second_timer_wake_enable <= 1'b0;
      first_timer_wake_enable  <= 1'b0;
      watchdog_stop_disable    <= 1'b0;
      wake_or_measure_select   <= 1'b0;
      wake_pin_a_enable        <= 1'b1;
      wake_pin_b_enable        <= 1'b1;
      wake_pin_c_enable        <= 1'b1;
      wake_pin_a_pull_select   <= wsc_pkg::PULL_NONE;
      wake_pin_b_pull_select   <= wsc_pkg::PULL_NONE;
      wake_pin_c_pull_select   <= wsc_pkg::PULL_NONE;
      wake_pin_level_status    <= 3'h0;
      int_trigger              <= 1'b0;
    end else begin
      second_timer_wake_enable <= next_int_wake[wsc_pkg::TIMER2_WAKE_BIT];
      first_timer_wake_enable  <= next_int_wake[wsc_pkg::TIMER1_WAKE_BIT];
      watchdog_stop_disable    <= next_int_wake[wsc_pkg::WD_STOP_BIT];
      wake_or_measure_select   <= next_meas;
      wake_pin_a_enable        <= next_en[0];
      wake_pin_b_enable        <= next_en[1];
      wake_pin_c_enable        <= next_en[2];
      wake_pin_a_pull_select   <= next_pull_ctrl[wsc_pkg::PULL_A_LSB +: 2];
      wake_pin_b_pull_select   <= next_pull_ctrl[wsc_pkg::PULL_B_LSB +: 2];
      wake_pin_c_pull_select   <= next_pull_ctrl[wsc_pkg::PULL_C_LSB +: 2];
      wake_pin_level_status    <= next_level;
      int_trigger              <= next_int;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  // A plain host write to the internal register with no competing event.
  sequence host_int_write_s;
    hit_int && !soft_reset && !wd_update_valid;
  endsequence

  // A fail-safe entry that is not overridden by a soft reset.
  sequence fail_entry_s;
    fail_safe_entry && !soft_reset;
  endsequence

  // A restart entry that neither fail-safe nor soft reset overrides.
  sequence restart_s;
    restart_entry && !fail_safe_entry && !soft_reset;
  endsequence

  ext_reset_value_a: assert property (@(posedge core_clk) rst |=> ext_wake == wsc_pkg::EXT_WAKE_RST)
    else $error("External register not 0x07 after reset.");
  int_soft_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    soft_reset |=> int_wake == 8'h00 && pull_ctrl == 8'h00 && !first_timer_wake_enable)
    else $error("Soft reset did not clear internal and pull registers.");
  fail_safe_force_a: assert property (@(posedge core_clk) disable iff (rst)
    fail_entry_s |=> ext_wake[2:0] == 3'h7 && ext_wake[6] == 1'b0 && ext_wake[4:3] == 2'h0
      && ext_wake[7] == $past(ext_wake[7]) && wake_pin_c_enable)
    else $error("Fail-safe entry did not force wake enables.");
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    (int_wake & 8'h3B) == 8'h00 && (ext_wake & 8'h58) == 8'h00 && (pull_ctrl & 8'hC0) == 8'h00)
    else $error("Reserved register bit is set.");
  timer_wake_write_a: assert property (@(posedge core_clk) disable iff (rst)
    host_int_write_s |=> second_timer_wake_enable == $past(reg_wr_data[7])
      && first_timer_wake_enable == $past(reg_wr_data[6]))
    else $error("Timer wake enables did not follow the write.");
  wd_device_update_a: assert property (@(posedge core_clk) disable iff (rst)
    wd_update_valid && !soft_reset |=> watchdog_stop_disable == $past(wd_update_value))
    else $error("Watchdog bit did not take the device update.");
  measure_override_a: assert property (@(posedge core_clk) disable iff (rst)
    wake_or_measure_select |-> !wake_pin_a_enable && !wake_pin_b_enable)
    else $error("Pin a or b enabled in measure mode.");
  level_masked_a: assert property (@(posedge core_clk) disable iff (rst)
    wake_or_measure_select |-> wake_pin_level_status[1:0] == 2'h0)
    else $error("Pin a or b level shown in measure mode.");
  int_scope_a: assert property (@(posedge core_clk) disable iff (rst)
    status_event_any && !wake_event_any |=> int_trigger == $past(ext_wake[7]))
    else $error("Interrupt scope not honoured.");
  pin_b_enable_a: assert property (@(posedge core_clk) disable iff (rst)
    wake_pin_b_enable == (ext_wake[1] && !ext_wake[5]))
    else $error("Pin b enable mismatch.");
  pull_select_a: assert property (@(posedge core_clk) disable iff (rst)
    {wake_pin_c_pull_select, wake_pin_b_pull_select, wake_pin_a_pull_select} == pull_ctrl[5:0])
    else $error("Pull select mismatch.");
  unmapped_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd_en && (reg_addr < 7'h06 || reg_addr > 7'h08) |=> reg_rd_valid && reg_rd_data == 8'h00)
    else $error("Unmapped read returned data.");
  restart_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    restart_s |=> ext_wake == ($past(ext_wake) & wsc_pkg::RESTART_KEEP) && wake_pin_c_enable == $past(ext_wake[2]))
    else $error("Restart changed a kept external bit.");
  pin_a_enable_a: assert property (@(posedge core_clk) disable iff (rst)
    wake_pin_a_enable == (ext_wake[0] && !ext_wake[5]))
    else $error("Pin a enable mismatch.");
  pin_c_enable_a: assert property (@(posedge core_clk) disable iff (rst)
    wake_pin_c_enable == ext_wake[2])
    else $error("Pin c enable mismatch.");
  // external read data
  // Reserved bits are already zero in the register, so the answer is the stored byte.
  ext_read_data_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd_en && reg_addr == wsc_pkg::EXT_WAKE_ADDR |=> reg_rd_valid && reg_rd_data == $past(ext_wake))
    else $error("External register read returned wrong data.");

endmodule // wsc_wake_regs
